/* hdl/pireg_pkg.sv */
// Constants, settings carrier and source carrier for the PI regulator
// Notes on behaviour
// (R01) Mode 0 disables, 1 runs standalone, 3 trims the speed command.
// (R02) Feedback comes from second analog input only when its function is B.
// (R03) Setpoint: fixed value, else serial serial_setpoint_value if flag bit 1, else ref.
// (R04) Second analog function 16 holds first minus second input at the offset.
// (R05) Proportional term is error times gain, 0 to 25.00, default 2.00.
// (R06) Smaller integral time integrates harder; time zero turns integral off.
// (R07) Integral term magnitude clamped to the integral limit, default 100.0%.
// (R08) Regulator output magnitude clamped to the output limit, default 100.0%.
// (R09) Outside differential mode the signed offset is added each update.
// (R10) First order lag with time constant up to 10.00 s; zero bypasses.
// (R11) Polarity 0 raises speed on low feedback; polarity 1 lowers it.
// (R12) Output is multiplied by output gain, 0 to 25.0, default 1.0.
// (R13) Negative output clamps to zero, or commands reverse when selected.
// (R14) Loss response: 0 nothing, 1 alarm only, 2 coast and fault relay.
// (R15) With loss detection enabled a digital output marks feedback loss.
// (R16) Loss declared after feedback stays below level for the loss time.
// (R17) Bypassed for mode 0, during jog, or while the disable input is on.
// (R18) Computed at a fixed sample period in saturating fixed point.
package pireg_pkg;
   localparam int CLK_NS = 8;
   localparam int SAMPLE_NS = 1000000;
   localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
   localparam int DSEC_NS = 100000000;
   localparam int CSEC_NS = 10000000;
   localparam int SMP_PER_DSEC = DSEC_NS / SAMPLE_NS;
   localparam int SMP_PER_CSEC = CSEC_NS / SAMPLE_NS;
   localparam int FULL_SCALE = 10000;
   localparam int TENTH_PCT = 10;
   localparam int WHOLE_PCT = 100;
   localparam int KP_DIV = 100;
   localparam int GAIN_DIV = 10;
   localparam int FILT_FRAC = 10;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_SOLO = 2'h1;
   localparam logic [1:0] MODE_TRIM = 2'h3;
   localparam logic [4:0] A2_FEEDBACK = 5'h0b;
   localparam logic [4:0] A2_DIFF = 5'h10;
   localparam logic [1:0] LOSS_NONE = 2'h0;
   localparam logic [1:0] LOSS_ALARM = 2'h1;
   localparam logic [1:0] LOSS_FAULT = 2'h2;
   localparam logic [7:0] SERIAL_SP_ADDR = 8'h06;
   localparam logic [7:0] SERIAL_FLAG_ADDR = 8'h0f;
   localparam int FLAG_SP_BIT = 1;
   localparam logic [15:0] SERIAL_RST = 16'h0000;
   localparam logic [15:0] KP_DEF = 16'h00c8;
   localparam logic [15:0] TI_DEF = 16'h0032;
   localparam logic [15:0] LIM_DEF = 16'h03e8;
   localparam logic [15:0] GAIN_DEF = 16'h000a;
   localparam logic [15:0] LOSS_T_DEF = 16'h000a;
   typedef enum logic [1:0] {
      LS_OK = 2'b00,
      LS_TIMING = 2'b01,
      LS_LOST = 2'b10
   } pireg_loss_t;
   // Settings: gains 0.01 / 0.1, times 0.1 s / 0.01 s, limits 0.1 %
   typedef struct packed {
      logic [1:0] regulator_mode_select;
      logic [15:0] proportional_gain;
      logic [15:0] integral_time;
      logic [15:0] integral_limit;
      logic [15:0] output_limit;
      logic signed [15:0] offset_adjust;
      logic [15:0] primary_delay_constant;
      logic output_polarity;
      logic [15:0] output_gain;
      logic reverse_select;
      logic [1:0] feedback_loss_response;
      logic [7:0] feedback_loss_level;
      logic [15:0] feedback_loss_time;
      logic fixed_setpoint_enable;
      logic [15:0] fixed_setpoint_value;
      logic [4:0] second_analog_function;
      logic [1:0] speed_reference_source;
   } pireg_cfg_t;
   // Inputs in 0.01 % of full scale
   typedef struct packed {
      logic [15:0] preset_step_reference;
      logic [15:0] first_analog_input;
      logic [15:0] second_analog_input;
      logic [15:0] serial_reference;
      logic [15:0] option_reference;
   } pireg_src_t;
endpackage

/* hdl/pireg_regulator.sv */
// PI process regulator with setpoint select and feedback loss detection
module pireg_regulator #(
   parameter int SAMPLE_CYC = pireg_pkg::SAMPLE_CYC
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire pireg_pkg::pireg_cfg_t CFG_I,
   input wire pireg_pkg::pireg_src_t SRC_I,
   input wire logic JOG_I,
   input wire logic PI_OFF_DI_I,
   input wire logic REG_WE_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [15:0] REG_WDATA_I,
   output logic [15:0] REG_RDATA_O,
   output logic signed [15:0] SPEED_CMD_O,
   output logic REVERSE_O,
   output logic PI_ACTIVE_O,
   output logic LOSS_ALARM_O,
   output logic LOSS_DO_O,
   output logic FAULT_RELAY_O,
   output logic COAST_O
);
   typedef logic signed [31:0] s32_t;
   // Symmetric saturation to plus or minus lim
   function automatic s32_t clamp(input s32_t v, input s32_t lim);
      clamp = (v > lim) ? lim : ((v < -lim) ? -lim : v);
   endfunction
   function automatic s32_t u16(input logic [15:0] v);
      u16 = s32_t'({16'h0000, v});
   endfunction
   logic [31:0] tick_cnt_ff, nxt_tick_cnt;
   logic tick_ff, nxt_tick;
   logic [15:0] sp_reg_ff, nxt_sp_reg, flag_reg_ff, nxt_flag_reg;
   logic [15:0] rdata_ff, nxt_rdata;
   logic signed [47:0] iacc_ff, nxt_iacc, iacc_try;
   s32_t yacc_ff, nxt_yacc;
   logic signed [15:0] cmd_ff, nxt_cmd;
   logic rev_ff, nxt_rev, act_ff, nxt_act;
   pireg_pkg::pireg_loss_t ls_ff, nxt_ls;
   logic [23:0] cnt_ff, nxt_cnt;
   logic alarm_ff, nxt_alarm, do_ff, nxt_do, fault_ff, nxt_fault;
   s32_t ref_v, sp_v, fb_v, err, p_term, i_term, i_try, pi_v, x_v, y_v;
   s32_t z_v, out_v, loss_lim;
   logic diff_mode, fb_mode, active, fb_low, i_div0;
   logic signed [47:0] i_den;
   // Sample divider: one-cycle enable per sample period
   always_comb begin
      nxt_tick = 1'b0;
      nxt_tick_cnt = tick_cnt_ff + 32'h1;
      if (tick_cnt_ff >= 32'(SAMPLE_CYC - 1)) begin // [R18]
         nxt_tick_cnt = 32'h0;
         nxt_tick = 1'b1;
      end
   end
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         tick_cnt_ff <= 32'h0;
         tick_ff <= 1'b0;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
         tick_ff <= nxt_tick;
      end
   end

   // Serial setpoint and flag registers, registered read data
   always_comb begin
      nxt_sp_reg = sp_reg_ff;
      nxt_flag_reg = flag_reg_ff;
      if (REG_WE_I && REG_ADDR_I == pireg_pkg::SERIAL_SP_ADDR) begin
         nxt_sp_reg = REG_WDATA_I;
      end
      if (REG_WE_I && REG_ADDR_I == pireg_pkg::SERIAL_FLAG_ADDR) begin
         nxt_flag_reg = REG_WDATA_I;
      end
      case (REG_ADDR_I)
         pireg_pkg::SERIAL_SP_ADDR: nxt_rdata = sp_reg_ff;
         pireg_pkg::SERIAL_FLAG_ADDR: nxt_rdata = flag_reg_ff;
         default: nxt_rdata = 16'h0000;
      endcase
   end
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         sp_reg_ff <= pireg_pkg::SERIAL_RST;
         flag_reg_ff <= pireg_pkg::SERIAL_RST;
         rdata_ff <= 16'h0000;
      end else begin
         sp_reg_ff <= nxt_sp_reg;
         flag_reg_ff <= nxt_flag_reg;
         rdata_ff <= nxt_rdata;
      end
   end

   // Reference, setpoint, feedback and error selection
   always_comb begin
      case (CFG_I.speed_reference_source)
         2'h0: ref_v = u16(SRC_I.preset_step_reference);
         2'h1: ref_v = u16(SRC_I.first_analog_input);
         2'h2: ref_v = u16(SRC_I.serial_reference);
         default: ref_v = u16(SRC_I.option_reference);
      endcase
      if (CFG_I.fixed_setpoint_enable) begin // [R03]
         sp_v = u16(CFG_I.fixed_setpoint_value);
      end else if (flag_reg_ff[pireg_pkg::FLAG_SP_BIT]) begin // [R03]
         sp_v = u16(sp_reg_ff);
      end else begin
         sp_v = ref_v; // [R03]
      end
      diff_mode = CFG_I.second_analog_function == pireg_pkg::A2_DIFF;
      fb_mode = CFG_I.second_analog_function == pireg_pkg::A2_FEEDBACK;
      fb_v = fb_mode ? u16(SRC_I.second_analog_input) : 32'sh0; // [R02]
      if (diff_mode) begin // [R04]
         err = s32_t'(CFG_I.offset_adjust) * pireg_pkg::TENTH_PCT
            - (u16(SRC_I.first_analog_input)
            - u16(SRC_I.second_analog_input));
      end else begin
         err = sp_v - fb_v;
      end
      if (CFG_I.output_polarity) begin // [R11]
         err = -err;
      end
      active = (CFG_I.regulator_mode_select == pireg_pkg::MODE_SOLO
         || CFG_I.regulator_mode_select == pireg_pkg::MODE_TRIM)
         && !JOG_I && !PI_OFF_DI_I; // [R01] [R17]
   end

   // PI arithmetic, filter, output gain and trim addition
   always_comb begin
      p_term = err * u16(CFG_I.proportional_gain)
         / pireg_pkg::KP_DIV; // [R05]
      i_div0 = CFG_I.integral_time == 16'h0000;
      i_den = 48'(u16(CFG_I.integral_time) * pireg_pkg::SMP_PER_DSEC);
      iacc_try = iacc_ff + 48'(err);
      i_term = 32'sh0;
      i_try = 32'sh0;
      if (!i_div0) begin // [R06]
         i_term = s32_t'(iacc_ff / i_den);
         i_try = s32_t'(iacc_try / i_den);
      end
      i_term = clamp(i_term, u16(CFG_I.integral_limit)
         * pireg_pkg::TENTH_PCT); // [R07]
      pi_v = clamp(p_term + i_term, u16(CFG_I.output_limit)
         * pireg_pkg::TENTH_PCT); // [R08]
      x_v = diff_mode ? pi_v : pi_v + s32_t'(CFG_I.offset_adjust)
         * pireg_pkg::TENTH_PCT; // [R09]
      if (CFG_I.primary_delay_constant == 16'h0000) begin // [R10]
         nxt_yacc = x_v <<< pireg_pkg::FILT_FRAC;
      end else begin
         nxt_yacc = yacc_ff + ((x_v <<< pireg_pkg::FILT_FRAC) - yacc_ff)
            / (u16(CFG_I.primary_delay_constant)
            * pireg_pkg::SMP_PER_CSEC); // [R10]
      end
      y_v = nxt_yacc >>> pireg_pkg::FILT_FRAC;
      z_v = clamp(y_v * u16(CFG_I.output_gain) / pireg_pkg::GAIN_DIV,
         pireg_pkg::FULL_SCALE); // [R12]
      if (CFG_I.regulator_mode_select == pireg_pkg::MODE_TRIM) begin
         out_v = clamp(ref_v + z_v, pireg_pkg::FULL_SCALE); // [R01]
      end else begin
         out_v = z_v;
      end
   end

   // Regulator state and speed command update once per sample
   always_comb begin
      nxt_iacc = iacc_ff;
      nxt_cmd = cmd_ff;
      nxt_rev = rev_ff;
      nxt_act = act_ff;
      if (tick_ff) begin
         nxt_act = active;
         if (!active) begin // [R17]
            nxt_iacc = 48'sh0;
            nxt_cmd = ref_v[15:0];
            nxt_rev = 1'b0;
         end else begin
            if (i_div0) begin // [R06]
               nxt_iacc = 48'sh0;
            end else if (i_try == clamp(i_try, u16(CFG_I.integral_limit)
               * pireg_pkg::TENTH_PCT)) begin // [R07]
               nxt_iacc = iacc_try;
            end
            if (out_v < 0 && !CFG_I.reverse_select) begin // [R13]
               nxt_cmd = 16'sh0000;
               nxt_rev = 1'b0;
            end else begin
               nxt_cmd = out_v[15:0];
               nxt_rev = out_v < 0; // [R13]
            end
         end
         if (fault_ff) begin // [R14]
            nxt_cmd = 16'sh0000;
            nxt_rev = 1'b0;
         end
      end
   end
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         iacc_ff <= 48'sh0;
         yacc_ff <= 32'sh0;
         cmd_ff <= 16'sh0000;
         rev_ff <= 1'b0;
         act_ff <= 1'b0;
      end else begin
         iacc_ff <= nxt_iacc;
         if (tick_ff) begin
            yacc_ff <= active ? nxt_yacc : 32'sh0;
         end
         cmd_ff <= nxt_cmd;
         rev_ff <= nxt_rev;
         act_ff <= nxt_act;
      end
   end

   // Feedback loss timer and response
   always_comb begin
      loss_lim = u16(CFG_I.feedback_loss_time) * pireg_pkg::SMP_PER_DSEC;
      fb_low = fb_v < u16({8'h00, CFG_I.feedback_loss_level})
         * pireg_pkg::WHOLE_PCT;
      nxt_ls = ls_ff;
      nxt_cnt = cnt_ff;
      if (!fb_mode
         || CFG_I.feedback_loss_response == pireg_pkg::LOSS_NONE) begin
         nxt_ls = pireg_pkg::LS_OK;
         nxt_cnt = 24'h0;
      end else if (tick_ff) begin
         case (ls_ff)
            pireg_pkg::LS_OK, pireg_pkg::LS_TIMING: begin
               if (!fb_low) begin
                  nxt_ls = pireg_pkg::LS_OK;
                  nxt_cnt = 24'h0;
               end else if (s32_t'({8'h00, cnt_ff}) + 1 >= loss_lim) begin
                  nxt_ls = pireg_pkg::LS_LOST; // [R16]
               end else begin
                  nxt_ls = pireg_pkg::LS_TIMING;
                  nxt_cnt = cnt_ff + 24'h1;
               end
            end
            pireg_pkg::LS_LOST: begin
               if (!fb_low) begin
                  nxt_ls = pireg_pkg::LS_OK;
                  nxt_cnt = 24'h0;
               end
            end
            default: begin
               nxt_ls = pireg_pkg::LS_OK;
               nxt_cnt = 24'h0;
            end
         endcase
      end
      nxt_do = nxt_ls == pireg_pkg::LS_LOST; // [R15]
      nxt_alarm = nxt_do && CFG_I.feedback_loss_response
         == pireg_pkg::LOSS_ALARM; // [R14]
      nxt_fault = (fault_ff || nxt_do) && CFG_I.feedback_loss_response
         == pireg_pkg::LOSS_FAULT; // [R14]
   end
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ls_ff <= pireg_pkg::LS_OK;
         cnt_ff <= 24'h0;
         do_ff <= 1'b0;
         alarm_ff <= 1'b0;
         fault_ff <= 1'b0;
      end else begin
         ls_ff <= nxt_ls;
         cnt_ff <= nxt_cnt;
         do_ff <= nxt_do;
         alarm_ff <= nxt_alarm;
         fault_ff <= nxt_fault;
      end
   end

   // Outputs straight from flip-flops
   assign REG_RDATA_O = rdata_ff;
   assign SPEED_CMD_O = cmd_ff;
   assign REVERSE_O = rev_ff;
   assign PI_ACTIVE_O = act_ff;
   assign LOSS_ALARM_O = alarm_ff;
   assign LOSS_DO_O = do_ff;
   assign FAULT_RELAY_O = fault_ff;
   assign COAST_O = fault_ff;
   // Checks on the regulator behaviour
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   property p_mode_off;
      tick_ff && CFG_I.regulator_mode_select == pireg_pkg::MODE_OFF
         |=> !act_ff;
   endproperty
   a_mode_off: assert property (p_mode_off) // [R01]
      else $error("regulator active with mode off");
   property p_bypass;
      tick_ff && (JOG_I || PI_OFF_DI_I) && !fault_ff
         |=> cmd_ff == $past(ref_v[15:0]) && iacc_ff == 0;
   endproperty
   a_bypass: assert property (p_bypass) // [R17]
      else $error("bypass did not pass the reference");
   property p_int_off;
      tick_ff && active && i_div0 |=> iacc_ff == 0;
   endproperty
   a_int_off: assert property (p_int_off) // [R06]
      else $error("integral ran with zero time");
   property p_out_lim;
      pi_v <= u16(CFG_I.output_limit) * 10
         && pi_v >= -(u16(CFG_I.output_limit) * 10);
   endproperty
   a_out_lim: assert property (p_out_lim) // [R08]
      else $error("output exceeds output limit");
   property p_no_rev;
      !CFG_I.reverse_select && tick_ff |=> !rev_ff && cmd_ff >= 0;
   endproperty
   a_no_rev: assert property (p_no_rev) // [R13]
      else $error("negative command without reverse");
   property p_loss_time;
      $rose(ls_ff == pireg_pkg::LS_LOST)
         |-> s32_t'({8'h00, $past(cnt_ff)}) + 1 >= $past(loss_lim);
   endproperty
   a_loss_time: assert property (p_loss_time) // [R16]
      else $error("loss declared before loss time");
   property p_loss_do;
      ls_ff == pireg_pkg::LS_LOST ##1 ls_ff == pireg_pkg::LS_LOST |-> do_ff;
   endproperty
   a_loss_do: assert property (p_loss_do) // [R15]
      else $error("loss output not set");
   // Alarm flop reflects the response setting of the cycle before
   property p_alarm_only;
      alarm_ff |-> !fault_ff
         && $past(CFG_I.feedback_loss_response) == pireg_pkg::LOSS_ALARM;
   endproperty
   a_alarm_only: assert property (p_alarm_only) // [R14]
      else $error("alarm with wrong response");
   property p_fault_coast;
      fault_ff && tick_ff
         && CFG_I.feedback_loss_response == pireg_pkg::LOSS_FAULT
         |=> cmd_ff == 0 && !rev_ff && COAST_O;
   endproperty
   a_fault_coast: assert property (p_fault_coast) // [R14]
      else $error("fault without coast");
   c_lost: cover property (ls_ff == pireg_pkg::LS_LOST);
   c_reverse: cover property (rev_ff && act_ff);
   c_trim: cover property (act_ff
      && CFG_I.regulator_mode_select == pireg_pkg::MODE_TRIM);
endmodule

/* testbench/pireg_source_model.sv */
// Model of the feedback transmitter and the setpoint sources
module pireg_source_model (
   input wire logic clk_i,
   input wire pireg_pkg::pireg_src_t want_i,
   output pireg_pkg::pireg_src_t src_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Levels change at the falling edge, clear of the sampling edge
   initial src_o = '0;
   always @(negedge clk_i) begin
      src_o <= want_i;
   end
endmodule

/* testbench/pireg_regulator_tb.sv */
// Self-checking bench for the PI process regulator
module pireg_regulator_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SC = 10;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic jog = 1'b0;
   logic pi_off = 1'b0;
   logic we = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata;
   logic signed [15:0] cmd;
   logic rev, act, alarm, ldo, relay, coast;
   pireg_pkg::pireg_cfg_t cfg = '0;
   pireg_pkg::pireg_src_t want = '0;
   pireg_pkg::pireg_src_t src;
   int fails = 0;
   int samples_checked = 0;
   logic [31:0] seed = 32'hff3e6c84;

   // Free-running core clock
   always #4 core_clk = ~core_clk;

   pireg_source_model pireg_source_model_inst (.clk_i(core_clk),
      .want_i(want), .src_o(src));
   pireg_regulator #(.SAMPLE_CYC(SC)) pireg_regulator_inst (
      .CORE_CLK_I(core_clk), .RST_I(rst), .CFG_I(cfg), .SRC_I(src),
      .JOG_I(jog), .PI_OFF_DI_I(pi_off), .REG_WE_I(we),
      .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
      .SPEED_CMD_O(cmd), .REVERSE_O(rev), .PI_ACTIVE_O(act),
      .LOSS_ALARM_O(alarm), .LOSS_DO_O(ldo), .FAULT_RELAY_O(relay),
      .COAST_O(coast));

   // Random source for setpoints and feedback
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic rnd(input int m, output int v);
      seed = lfsr(seed);
      v = int'(seed[15:0]) % m;
   endtask

   // Reference model of the proportional path from the bench settings
   function automatic int model(input int sp, input int fb);
      int e;
      int lim;
      e = cfg.output_polarity ? fb - sp : sp - fb;
      e = e * int'(cfg.proportional_gain) / 100;
      lim = int'(cfg.output_limit) * 10;
      if (e > lim) e = lim;
      if (e < -lim) e = -lim;
      e = e + int'($signed(cfg.offset_adjust)) * 10;
      e = e * int'(cfg.output_gain) / 10;
      if (e < 0 && !cfg.reverse_select) e = 0;
      return e;
   endfunction

   // Comparisons, one per kind of result
   task automatic chk_cmd(input logic signed [15:0] exp);
      samples_checked++;
      if (cmd !== exp) begin
         fails++;
         $display("Error %0t: command %0d expected %0d", $time, cmd, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string w);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t: %s is %b expected %b", $time, w, got, exp);
      end
   endtask
   task automatic chk_reg(input logic [15:0] exp);
      samples_checked++;
      if (rdata !== exp) begin
         fails++;
         $display("Error %0t: read %h expected %h", $time, rdata, exp);
      end
   endtask

   // Bus cycles and waits, all launched at the falling edge
   task automatic ticks(input int n);
      repeat (n * SC) @(negedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge core_clk);
      we = 1'b1;
      addr = a;
      wdata = d;
      @(negedge core_clk);
      we = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(negedge core_clk);
      addr = a;
      @(negedge core_clk);
      chk_reg(exp);
   endtask
   task automatic done(input string n);
      $display("Test %s done", n);
   endtask

   // Default settings, passing through bypass to clear the state
   task automatic base();
      @(negedge core_clk);
      cfg = '0;
      want = '0;
      cfg.proportional_gain = 16'h0064;
      cfg.integral_limit = pireg_pkg::LIM_DEF;
      cfg.output_limit = pireg_pkg::LIM_DEF;
      cfg.output_gain = pireg_pkg::GAIN_DEF;
      cfg.feedback_loss_time = pireg_pkg::LOSS_T_DEF;
      cfg.fixed_setpoint_enable = 1'b1;
      cfg.second_analog_function = pireg_pkg::A2_FEEDBACK;
      ticks(2);
      cfg.regulator_mode_select = pireg_pkg::MODE_SOLO;
   endtask
   task automatic lim(input logic [15:0] kp, input logic [15:0] ol,
         input logic [15:0] off, input logic [15:0] g, input int sp);
      cfg.proportional_gain = kp;
      cfg.output_limit = ol;
      cfg.offset_adjust = off;
      cfg.output_gain = g;
      cfg.fixed_setpoint_value = 16'(sp);
      ticks(3);
      chk_cmd(16'(model(sp, 0)));
   endtask

   task automatic summarize();
      $display("Checks made %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge core_clk);
      fails++;
      $display("Error %0t: run timed out", $time);
      summarize();
   end

   // Main sequence
   initial begin
      int a;
      int b;
      int e;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      wr(8'h06, 16'h1b58);
      rd(8'h06, 16'h1b58);
      wr(8'h20, 16'hffff);
      rd(8'h20, 16'h0000);
      rd(8'h0f, 16'h0000);
      done("registers");
      base();
      cfg.fixed_setpoint_enable = 1'b0;
      want.preset_step_reference = 16'h03e8;
      want.first_analog_input = 16'h07d0;
      want.serial_reference = 16'h0bb8;
      want.option_reference = 16'h0fa0;
      want.second_analog_input = 16'h01f4;
      for (int s = 0; s < 4; s++) begin
         cfg.speed_reference_source = 2'(s);
         ticks(3);
         chk_cmd(16'(model(1000 * (s + 1), 500)));
      end
      wr(8'h0f, 16'h0002);
      ticks(3);
      chk_cmd(16'(model(7000, 500)));
      cfg.fixed_setpoint_enable = 1'b1;
      cfg.fixed_setpoint_value = 16'h2328;
      ticks(3);
      chk_cmd(16'(model(9000, 500)));
      cfg.second_analog_function = 5'h00;
      ticks(3);
      chk_cmd(16'(model(9000, 0)));
      done("setpoint");
      base();
      cfg.proportional_gain = pireg_pkg::KP_DEF;
      for (int i = 0; i < 12; i++) begin
         rnd(5001, a);
         rnd(5001, b);
         @(negedge core_clk);
         cfg.fixed_setpoint_value = 16'(a);
         want.second_analog_input = 16'(b);
         cfg.output_polarity = i[0];
         cfg.reverse_select = i[1];
         ticks(3);
         e = model(a, b);
         chk_cmd(16'(e));
         chk_bit(rev, e < 0, "reverse");
      end
      done("polarity");
      base();
      lim(16'h09c4, 16'h01f4, 16'h0000, 16'h000a, 1000);
      lim(16'h0064, 16'h03e8, 16'h00c8, 16'h000a, 1000);
      lim(16'h0064, 16'h03e8, 16'hff9c, 16'h000a, 3000);
      lim(16'h0064, 16'h03e8, 16'h0000, 16'h0019, 2000);
      done("limits");
      base();
      cfg.proportional_gain = 16'h0000;
      cfg.fixed_setpoint_value = 16'h1388;
      ticks(3);
      chk_cmd(16'h0000);
      cfg.integral_time = 16'h0001;
      cfg.integral_limit = 16'h0064;
      ticks(5);
      chk_bit(cmd > 0 && cmd < 1000, 1'b1, "partial integral");
      ticks(60);
      chk_cmd(16'h03e8);
      done("integral");
      base();
      cfg.primary_delay_constant = 16'h000a;
      cfg.fixed_setpoint_value = 16'h03e8;
      ticks(2);
      chk_bit(cmd < 500, 1'b1, "filter start");
      ticks(800);
      chk_bit(cmd > 990 && cmd <= 1000, 1'b1, "filter end");
      done("filter");
      base();
      cfg.second_analog_function = pireg_pkg::A2_DIFF;
      cfg.fixed_setpoint_value = 16'h2328;
      cfg.offset_adjust = 16'h012c;
      cfg.reverse_select = 1'b1;
      want.first_analog_input = 16'h1770;
      want.second_analog_input = 16'h03e8;
      ticks(3);
      chk_cmd(16'hf830);
      chk_bit(rev, 1'b1, "reverse");
      done("differential");
      base();
      cfg.regulator_mode_select = pireg_pkg::MODE_TRIM;
      cfg.speed_reference_source = 2'h1;
      cfg.fixed_setpoint_value = 16'h1388;
      want.first_analog_input = 16'h07d0;
      want.second_analog_input = 16'h0fa0;
      ticks(3);
      chk_cmd(16'h0bb8);
      chk_bit(act, 1'b1, "active");
      for (int k = 0; k < 4; k++) begin
         base();
         cfg.speed_reference_source = 2'h1;
         cfg.fixed_setpoint_value = 16'h2328;
         want.first_analog_input = 16'h10e1;
         cfg.regulator_mode_select = 2'(k == 1 ? 2 : k == 0 ? 0 : 1);
         jog = (k == 2);
         pi_off = (k == 3);
         ticks(3);
         chk_cmd(16'h10e1);
         chk_bit(act, 1'b0, "active");
         jog = 1'b0;
         pi_off = 1'b0;
      end
      done("modes");
      for (int r = 0; r < 3; r++) begin
         base();
         cfg.fixed_setpoint_value = 16'h0bb8;
         cfg.feedback_loss_level = 8'h32;
         cfg.feedback_loss_time = 16'h0001;
         cfg.feedback_loss_response = 2'(r);
         ticks(95);
         chk_bit(ldo, 1'b0, "early loss");
         ticks(7);
         chk_bit(ldo, r != 0, "loss output");
         chk_bit(alarm, r == 1, "alarm");
         chk_bit(relay, r == 2, "relay");
         chk_bit(coast, r == 2, "coast");
         chk_cmd(r == 2 ? 16'h0000 : 16'h0bb8);
         want.second_analog_input = 16'h1770;
         ticks(2);
         chk_bit(alarm, 1'b0, "recovered");
      end
      done("loss");
      summarize();
   end
endmodule
